// ==== design/pmt_timer.sv ====
// Period match timer with AXI4-Lite register slave
// Operation
// (RULE_01) Count clocked by oscillator/4 through prescaler
// (RULE_02) Prescale codes: 00=1, 01=4, 1x=16
// (RULE_03) Count and period both 8 bits
// (RULE_04) Count and period compared continuously
// (RULE_05) Count wraps to zero after match
// (RULE_06) Each match advances postscaler
// (RULE_07) Postscale ratio is select plus one
// (RULE_08) Postscaler output sets match flag
// (RULE_09) Count/period accessible; reset 00 and ff
// (RULE_10) Run bit 2 starts and stops timer
// (RULE_11) Count/control writes, reset clear dividers
// (RULE_12) Control write keeps count value
// (RULE_13) Stopped timer holds count, no matches
// (RULE_14) Flag sticky until software clears it
`timescale 1ns/1ns
`include "pmt_cfg.svh"
module pmt_timer
  import pmt_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // Write address channel
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address and data channels
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Level interrupt, high while an enabled flag is set
  output logic             irq
);

  // ==========================================================
  // Timer state
  pmt_ctrl_t   ctrl_q,     ctrl_d;
  logic [7:0]  period_q,   period_d;
  logic [7:0]  count_q,    count_d;     // see RULE_03
  logic [1:0]  insn_q,     insn_d;
  logic [3:0]  pre_q,      pre_d;
  logic [3:0]  post_q,     post_d;
  logic        match_q,    match_d;
  logic        flag_q,     flag_d;
  logic        flag_en_q,  flag_en_d;

  // Bus channel state
  logic        aw_got_q,   aw_got_d;
  logic        w_got_q,    w_got_d;
  logic [11:0] awaddr_q,   awaddr_d;
  logic [31:0] wdata_q,    wdata_d;
  logic        bvalid_q,   bvalid_d;
  logic [1:0]  bresp_q,    bresp_d;
  logic        rvalid_q,   rvalid_d;
  logic [31:0] rdata_q,    rdata_d;
  logic [1:0]  rresp_q,    rresp_d;
  logic        wstrb0_q,   wstrb0_d;

  // Combinational strobes and taps
  logic        wr_fire;
  logic        wr_lane0;
  logic        wr_ok;
  logic        insn_tick;
  logic        pre_tick;
  logic [3:0]  pre_limit;
  logic        post_pulse;
  logic [31:0] rd_word;
  logic        rd_hit;

  // ==========================================================
  // AXI handshakes; address and data may arrive in either order.
  // Every ready is gated by the enable: while frozen the registers take
  // nothing, so a master never sees an AW, W or AR handshake complete then.
  assign s_axi_awready = clk_en && !aw_got_q && !bvalid_q;
  assign s_axi_wready  = clk_en && !w_got_q && !bvalid_q;
  assign s_axi_arready = clk_en && !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = flag_q && flag_en_q;

  // Write commits once both halves are held; registers are 8 bits so only lane 0 matters.
  // A write with lane 0 masked still answers OKAY but changes nothing.
  assign wr_fire  = aw_got_q && w_got_q && !bvalid_q;
  assign wr_lane0 = wr_fire && wstrb0_q;

  // Write address decode; holes in the map are refused with an error response
  always_comb begin
    unique case (awaddr_q)
      `PMT_OFF_CONTROL, `PMT_OFF_PERIOD, `PMT_OFF_COUNT,
      `PMT_OFF_FLAGS, `PMT_OFF_FLAG_CLEAR, `PMT_OFF_FLAG_ENABLE: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // Bus channel next state
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    // Each half is parked until its partner arrives
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_d = 1'b1;
      awaddr_d = {s_axi_awaddr[11:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_d  = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    // The response rises on the commit edge and stands until bready
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = wr_ok ? 2'h0 : 2'h2;   // Unmapped address answers SLVERR
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Read data is captured at the address handshake and then held, so a
    // slow master sees the value of that edge even if the timer moves on
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_word;
      rresp_d  = rd_hit ? 2'h0 : 2'h2;                             // Unmapped address answers SLVERR
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // ==========================================================
  // Read multiplexer; kept apart from the channel logic so the whole
  // register map can be seen in one place
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case ({s_axi_araddr[11:2], 2'h0})
      `PMT_OFF_CONTROL:     rd_word[7:0] = {1'b0, ctrl_q};         // Top bit unimplemented, reads zero
      `PMT_OFF_PERIOD:      rd_word[7:0] = period_q;               // see RULE_09
      `PMT_OFF_COUNT:       rd_word[7:0] = count_q;                // see RULE_09
      `PMT_OFF_FLAGS:       rd_word[`PMT_FLAG_BIT] = flag_q;
      `PMT_OFF_FLAG_CLEAR:  rd_word = 32'h0000_0000;               // Write-only, reads zero
      `PMT_OFF_FLAG_ENABLE: rd_word[`PMT_FLAG_BIT] = flag_en_q;
      default:              rd_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Timer datapath
  assign insn_tick = (insn_q == `PMT_INSN_DIV);                 // see RULE_01
  // Ratio limit of the prescaler counter; both upper codes select sixteen
  always_comb begin
    unique case (ctrl_q.pre_divider_select)                      // see RULE_02
      2'h0:    pre_limit = 4'h0;
      2'h1:    pre_limit = `PMT_PRE_DIV4;
      default: pre_limit = `PMT_PRE_DIV16;
    endcase
  end
  // Prescaler ticks on the instruction clock that completes its ratio
  assign pre_tick   = ctrl_q.timer_run && insn_tick && (pre_q == pre_limit);
  assign post_pulse = match_q && pre_tick && (post_q == ctrl_q.post_divider_select); // see RULE_07

  always_comb begin
    ctrl_d    = ctrl_q;
    period_d  = period_q;
    count_d   = count_q;
    insn_d    = insn_q + 2'h1;
    pre_d     = pre_q;
    post_d    = post_q;
    flag_d    = flag_q;
    flag_en_d = flag_en_q;
    // Prescaler only moves while running; stopped timer freezes prescaler, count and postscaler, but the instruction divider keeps counting
    if (ctrl_q.timer_run && insn_tick) begin                     // see RULE_13
      pre_d = pre_tick ? 4'h0 : pre_q + 4'h1;
    end
    // A registered match makes the next prescaler tick load zero instead of
    // incrementing, so the count dwells one tick at the period value
    if (pre_tick) begin
      if (match_q) begin
        count_d = 8'h00;                                         // see RULE_05
        post_d  = (post_q == ctrl_q.post_divider_select) ? 4'h0 : post_q + 4'h1; // see RULE_06
      end else begin
        count_d = count_q + 8'h01;
      end
    end
    // Postscaler wrap raises the sticky flag; only software or reset lowers it
    if (post_pulse) begin
      flag_d = 1'b1;                                             // see RULE_08
    end
    // Register writes come last so they override the counting above
    if (wr_lane0 && wr_ok) begin
      unique case (awaddr_q)
        `PMT_OFF_CONTROL: begin
          ctrl_d = wdata_q[6:0];                                 // see RULE_10
          pre_d  = 4'h0;                                         // see RULE_11
          post_d = 4'h0;
          insn_d = 2'h0;
          count_d = count_q;                                     // see RULE_12
        end
        `PMT_OFF_PERIOD: period_d = wdata_q[7:0];
        `PMT_OFF_COUNT: begin
          count_d = wdata_q[7:0];
          pre_d   = 4'h0;                                        // see RULE_11
          post_d  = 4'h0;
          insn_d  = 2'h0;
        end
        // Writing zero clears; an event in the same cycle wins
        `PMT_OFF_FLAGS: flag_d = post_pulse | (flag_q & wdata_q[`PMT_FLAG_BIT]); // see RULE_14
        `PMT_OFF_FLAG_CLEAR: flag_d = post_pulse | (flag_q & ~wdata_q[`PMT_FLAG_BIT]);
        `PMT_OFF_FLAG_ENABLE: flag_en_d = wdata_q[`PMT_FLAG_BIT];
        default: flag_d = flag_d;
      endcase
    end
  end

  // Continuous comparison, registered so the wrap lands on the next increment.
  // The flag therefore repeats every 4 * prescale * (period + 1) * (postscale + 1) clocks.
  assign match_d = ctrl_q.timer_run && (count_d == period_d);   // see RULE_04

  // ==========================================================
  // Bus registers; reset returns every channel to idle with nothing parked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
    end else if (clk_en) begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ==========================================================
  // Timer registers; synchronous reset also clears both dividers.
  // The enable freezes the dividers together with the count, so a
  // paused timer resumes with the same phase at which it stopped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= pmt_ctrl_t'(7'(`PMT_RST_CONTROL));          // Bit 7 is not stored
      period_q  <= `PMT_RST_PERIOD;                             // see RULE_09
      count_q   <= `PMT_RST_COUNT;
      insn_q    <= 2'h0;
      pre_q     <= 4'h0;                                        // see RULE_11
      post_q    <= 4'h0;
      match_q   <= 1'b0;
      flag_q    <= 1'b0;
      flag_en_q <= 1'b0;
    end else if (clk_en) begin
      ctrl_q    <= ctrl_d;
      period_q  <= period_d;
      count_q   <= count_d;
      insn_q    <= insn_d;
      pre_q     <= pre_d;
      post_q    <= post_d;
      match_q   <= match_d;
      flag_q    <= flag_d;
      flag_en_q <= flag_en_d;
    end
  end

endmodule

// ==== design/pmt_cfg.svh ====
// Register offsets, field positions, reset values and timing counts of the period match timer
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH
// ==========================================================
// Register byte offsets
`define PMT_OFF_CONTROL     12'h000
`define PMT_OFF_PERIOD      12'h004
`define PMT_OFF_COUNT       12'h008
`define PMT_OFF_FLAGS       12'h00c
`define PMT_OFF_FLAG_CLEAR  12'h010
`define PMT_OFF_FLAG_ENABLE 12'h014
// ==========================================================
// Field positions
`define PMT_PRE_LSB   0
`define PMT_PRE_MSB   1
`define PMT_RUN_BIT   2
`define PMT_POST_LSB  3
`define PMT_POST_MSB  6
`define PMT_FLAG_BIT  0
// ==========================================================
// Reset values
`define PMT_RST_CONTROL 8'h00
`define PMT_RST_PERIOD  8'hff
`define PMT_RST_COUNT   8'h00
// ==========================================================
// Timing: one instruction cycle is four system oscillator cycles
`define PMT_INSN_DIV    2'h3
`define PMT_PRE_DIV4    4'h3
`define PMT_PRE_DIV16   4'hf
`endif

// ==== design/pmt_pkg.sv ====
// Types shared by the period match timer
package pmt_pkg;
  // Decoded control register
  typedef struct packed {
    logic [3:0] post_divider_select;
    logic       timer_run;
    logic [1:0] pre_divider_select;
  } pmt_ctrl_t;

  // AXI write handshake states
  typedef enum logic [1:0] {
    PMT_W_IDLE,
    PMT_W_RESP
  } pmt_wstate_t;
endpackage

// ==== testbench/pmt_timer_sva.sv ====
// Port assertions for the period match timer
`timescale 1ns/1ns
module pmt_timer_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  // ==========================================================
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  hold_bresp_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  hold_rdata_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
    ##1 clk_en |=> s_axi_bvalid)
    else $error("write answer late");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  // Holes in the map answer with an error and zero data
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && clk_en && s_axi_araddr[11:2] > 10'h005
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("register wider than a byte");
  // Only a register write may lower the interrupt
  irq_sticky_a: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("interrupt fell without a write");
endmodule
bind pmt_timer pmt_timer_sva chk (.aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

// ==== testbench/pmt_timer_tb.sv ====
// Self-checking bench for the period match timer
`timescale 1ns/1ns
`include "pmt_cfg.svh"
module pmt_timer_tb
  import pmt_pkg::*;
;
  logic        aclk = 0, aresetn = 0, clk_en = 1, irq;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0]  wstrb = 4'hf, ws = 4'hf;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, br, rr;
  int          failures = 0, n_compared = 0, cyc = 0;
  always #4 aclk = ~aclk;
  pmt_timer dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  // ==========================================================
  // Bus cycles; ready is raised a cycle late so the hold rules get exercised
  task wr(input logic [11:0] a, input logic [7:0] v);
    awaddr <= a; wdata <= {24'h0, v}; wstrb <= ws; awvalid <= 1; wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      bready <= bvalid && !bready;
    end while (!(bvalid && bready));
    br = bresp;
  endtask
  task rd(input logic [11:0] a);
    araddr <= a; arvalid <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      rready <= rvalid && !rready;
    end while (!(rvalid && rready));
    d = rdata; rr = rresp;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    rd(`PMT_OFF_CONTROL); chk("control", 32'h0, d);
    chk("control resp", 32'h0, {30'h0, rr});
    wr(12'h018, 8'h00);
    chk("unmapped bresp", 32'h2, {30'h0, br});
    rd(`PMT_OFF_PERIOD); chk("period", 32'hff, d);
    rd(`PMT_OFF_COUNT); chk("count", 32'h0, d);
    rd(12'h018); chk("unmapped resp", 32'h2, {30'h0, rr});
    $display("reset values done");
  endtask
  task t_access;
    wr(`PMT_OFF_PERIOD, 8'h5a); chk("bresp", 32'h0, {30'h0, br});
    ws = 4'he; wr(`PMT_OFF_PERIOD, 8'h11); ws = 4'hf; // Strobe off: ignored
    rd(`PMT_OFF_PERIOD); chk("period", 32'h5a, d);
    wr(`PMT_OFF_COUNT, 8'ha5);
    wr(`PMT_OFF_CONTROL, 8'hfb);
    rd(`PMT_OFF_CONTROL); chk("control", 32'h7b, d);
    repeat (40) @(posedge aclk);
    rd(`PMT_OFF_COUNT); chk("count held", 32'ha5, d);
    $display("register access done");
  endtask
  // Frozen enable: 200 idle clocks would add three counts at prescale 16
  task t_freeze;
    wr(`PMT_OFF_PERIOD, 8'hff);
    wr(`PMT_OFF_COUNT, 8'h00);
    wr(`PMT_OFF_CONTROL, 8'h06);
    clk_en <= 1'b0;
    repeat (200) @(posedge aclk);
    clk_en <= 1'b1;
    rd(`PMT_OFF_COUNT);
    chk("count frozen", 32'h0, d);
    wr(`PMT_OFF_CONTROL, 8'h00);
    $display("clock enable done");
  endtask
  task t_period(input logic [1:0] pre, input logic [3:0] post, input logic [7:0] per, input int exp);
    pmt_ctrl_t c;
    int        n;
    c = '{post, 1'b1, pre};
    n = 0;
    wr(`PMT_OFF_CONTROL, 8'h00);
    wr(`PMT_OFF_PERIOD, per);
    wr(`PMT_OFF_FLAG_CLEAR, 8'h01);
    wr(`PMT_OFF_FLAG_ENABLE, 8'h01);
    wr(`PMT_OFF_COUNT, 8'h00);
    wr(`PMT_OFF_CONTROL, {1'b0, c});
    while (irq !== 1'b1) begin
      @(posedge aclk);
      n++;
    end
    n_compared++;
    if (n < exp - 3 || n > exp + 3) begin
      failures++;
      $display("ERROR flag delay expected %0d seen %0d", exp, n);
    end
    $display("period case %0d done", exp);
  endtask
  task t_flag;
    wr(`PMT_OFF_CONTROL, 8'h00);
    rd(`PMT_OFF_FLAGS); chk("flag sticky", 32'h1, d);
    wr(`PMT_OFF_FLAG_ENABLE, 8'h00); chk("irq masked", 32'h0, {31'h0, irq});
    wr(`PMT_OFF_FLAG_ENABLE, 8'h01); chk("irq back", 32'h1, {31'h0, irq});
    wr(`PMT_OFF_FLAG_CLEAR, 8'h01); chk("irq cleared", 32'h0, {31'h0, irq});
    rd(`PMT_OFF_FLAGS); chk("flag clear", 32'h0, d);
    wr(`PMT_OFF_PERIOD, 8'h00);
    wr(`PMT_OFF_COUNT, 8'h00);
    wr(`PMT_OFF_CONTROL, 8'h04);
    repeat (8) @(posedge aclk);
    wr(`PMT_OFF_CONTROL, 8'h00);
    wr(`PMT_OFF_FLAGS, 8'h01);
    rd(`PMT_OFF_FLAGS);
    chk("flag kept by one", 32'h1, d);
    wr(`PMT_OFF_FLAGS, 8'h00);
    rd(`PMT_OFF_FLAGS);
    chk("flag cleared by zero", 32'h0, d);
    chk("irq after zero", 32'h0, {31'h0, irq});
    $display("flag done");
  endtask
  task give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // Watchdog: whole run needs under two thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      $display("ERROR timeout");
      give_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_access;
    t_freeze;
    t_period(2'h0, 4'h0, 8'h03, 16);
    t_period(2'h1, 4'h1, 8'h02, 96);
    t_period(2'h2, 4'h0, 8'h01, 128);
    t_period(2'h3, 4'hf, 8'h00, 1024);
    t_flag;
    give_verdict;
  end
endmodule
